// File: dtsb_consts.vh
`ifndef DTSB_CONSTS_VH
`define DTSB_CONSTS_VH
`define DTSB_ADDR_RXDATA    12'h000
`define DTSB_ADDR_TXDATA    12'h004
`define DTSB_ADDR_CTRL      12'h008
`define DTSB_ADDR_STATUS    12'h00c
`define DTSB_ADDR_GTP       12'h010
`define DTSB_ADDR_GTA       12'h014
`define DTSB_CTRL_TONE_OUTPUT_ENABLE      0
`define DTSB_CTRL_CPMODE    1
`define DTSB_CTRL_IRQEN     2
`define DTSB_CTRL_BURST     3
`define DTSB_ST_TXREADY     1
`define DTSB_ST_RXVALID     2
`define DTSB_ST_DSTEER      3
`define DTSB_CTRL_RESET     4'h0
`define DTSB_GTP_RESET      24'h00f000
`define DTSB_GTA_RESET      24'h00f000
`define DTSB_SETTLE_CYC     4
`define DTSB_CLK_HZ         100000000
`define DTSB_XTAL_HZ        3579545
`define DTSB_BURST_MS       51
`define DTSB_PHASE_BITS     24
`define DTSB_SEGMENTS       32
`endif

// File: dtsb_tone_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "dtsb_consts.vh"
// One tone channel: segment divider stepping a 32-entry sine ROM
module dtsb_tone_gen #(
   parameter DIV_W = 12
) (
   input  wire             clock,
   input  wire             sys_rst,
   input  wire             tick,
   input  wire             run,
   input  wire [DIV_W-1:0] divCount,
   output reg  [7:0]       sample
);
   reg  [DIV_W-1:0] divCnt;
   reg  [4:0]       segIndex;
   reg  [7:0]       romWord;
   // Quarter-symmetric table would save area; full table kept for clarity
   always @* begin
      case (segIndex)
         5'h00: romWord = 8'h80;  5'h01: romWord = 8'h98;
         5'h02: romWord = 8'hb0;  5'h03: romWord = 8'hc6;
         5'h04: romWord = 8'hda;  5'h05: romWord = 8'hea;
         5'h06: romWord = 8'hf6;  5'h07: romWord = 8'hfd;
         5'h08: romWord = 8'hff;  5'h09: romWord = 8'hfd;
         5'h0a: romWord = 8'hf6;  5'h0b: romWord = 8'hea;
         5'h0c: romWord = 8'hda;  5'h0d: romWord = 8'hc6;
         5'h0e: romWord = 8'hb0;  5'h0f: romWord = 8'h98;
         5'h10: romWord = 8'h80;  5'h11: romWord = 8'h67;
         5'h12: romWord = 8'h4f;  5'h13: romWord = 8'h39;
         5'h14: romWord = 8'h25;  5'h15: romWord = 8'h15;
         5'h16: romWord = 8'h09;  5'h17: romWord = 8'h02;
         5'h18: romWord = 8'h00;  5'h19: romWord = 8'h02;
         5'h1a: romWord = 8'h09;  5'h1b: romWord = 8'h15;
         5'h1c: romWord = 8'h25;  5'h1d: romWord = 8'h39;
         5'h1e: romWord = 8'h4f;  5'h1f: romWord = 8'h67;
         default: romWord = 8'h80;
      endcase
   end
   always @(posedge clock) begin
      if (sys_rst || !run) begin
         divCnt   <= {DIV_W{1'b0}};
         segIndex <= 5'h00;
         sample   <= 8'h80;
      end else begin
         sample <= romWord;
         if (tick) begin
            if (divCnt >= divCount - 1'b1) begin
               divCnt <= {DIV_W{1'b0}};
               segIndex <= segIndex + 5'h01;
            end else begin
               divCnt <= divCnt + 1'b1;
            end
         end
      end
   end
endmodule // dtsb_tone_gen
`default_nettype wire

// File: dtsb_core.v
`timescale 1ns/1ps
`default_nettype none
`include "dtsb_consts.vh"
module dtsb_core #(
   parameter BURST_MS = `DTSB_BURST_MS
) (
   input  wire        clock,
   input  wire        sys_rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        early_steer,
   input  wire [3:0]  detected_code,
   input  wire        cp_in_band,
   input  wire        cp_limited,
   output reg         guard_drive,
   output reg         irq_or_tone_square_oe,
   output reg         delayed_steer,
   output reg  [3:0]  rx_code_bits,
   output reg  [7:0]  low_tone_sample,
   output reg  [7:0]  high_tone_sample,
   output reg         tone_active
);
   localparam ST_IDLE    = 2'd0;
   localparam ST_PRESENT = 2'd1;
   localparam ST_HELD    = 2'd2;
   localparam ST_ABSENT  = 2'd3;
   localparam B_IDLE  = 2'd0;
   localparam B_TONE  = 2'd1;
   localparam B_PAUSE = 2'd2;
   // Crystal tick by phase accumulation: step is truncated, so the long-term rate runs slightly below the crystal at 100 MHz
   localparam [63:0] PHASE_FULL =
      ((64'd1 << `DTSB_PHASE_BITS) * `DTSB_XTAL_HZ) / `DTSB_CLK_HZ;
   localparam [23:0] PHASE_STEP  = PHASE_FULL[23:0];
   localparam [63:0] BURST_FULL  = (64'd1 * BURST_MS * `DTSB_CLK_HZ) / 1000;
   localparam [31:0] BURST_CYC   = BURST_FULL[31:0];
   localparam [31:0] SETTLE_FULL = `DTSB_SETTLE_CYC - 1;
   localparam [3:0]  SETTLE_LAST = SETTLE_FULL[3:0];
   reg  [1:0]  syncSteer;
   reg  [1:0]  syncBand;
   reg  [1:0]  syncSquare;
   reg  [3:0]  codeMeta;
   reg  [3:0]  codeSync;
   reg  [3:0]  ctrl;
   reg  [23:0] gtpCount;
   reg  [23:0] gtaCount;
   reg  [3:0]  txCode;
   reg         txReady;
   reg         rxValid;
   reg         irqPend;
   reg  [1:0]  steerState;
   reg  [23:0] guardCnt;
   reg  [3:0]  pendCode;
   reg  [3:0]  settleCnt;
   reg         settling;
   reg  [23:0] phaseAcc;
   reg         xtalTick;
   reg  [1:0]  burstState;
   reg  [31:0] burstCnt;
   reg  [11:0] lowDiv;
   reg  [11:0] highDiv;
   wire [7:0]  lowSample;
   wire [7:0]  highSample;
   wire [24:0] nextPhase;
   wire        steerNow;
   wire        cpMode;
   wire        setupWr;
   wire        accessRd;
   wire        burstOn;
   wire        genRun;
   wire [31:0] burstLimit;
   assign steerNow  = syncSteer[1];
   assign cpMode    = ctrl[`DTSB_CTRL_CPMODE];
   assign setupWr   = psel && penable && pwrite;
   assign accessRd  = psel && penable && !pwrite;
   assign burstOn   = ctrl[`DTSB_CTRL_BURST];
   assign nextPhase = {1'b0, phaseAcc} + {1'b0, PHASE_STEP};
   assign burstLimit = cpMode ? {BURST_CYC[30:0], 1'b0} : BURST_CYC;
   assign genRun = ctrl[`DTSB_CTRL_TONE_OUTPUT_ENABLE] && (!burstOn || burstState == B_TONE);
   // Second stage of each synchroniser is the only reader of the first
   always @(posedge clock) begin
      if (sys_rst) begin
         syncSteer  <= 2'b00;
         syncBand   <= 2'b00;
         syncSquare <= 2'b00;
         codeMeta   <= 4'h0;
         codeSync   <= 4'h0;
      end else begin
         syncSteer  <= {syncSteer[0], early_steer};
         syncBand   <= {syncBand[0], cp_in_band};
         syncSquare <= {syncSquare[0], cp_limited};
         codeMeta   <= detected_code;
         codeSync   <= codeMeta;
      end
   end
   always @(posedge clock) begin
      if (sys_rst) begin
         phaseAcc <= 24'h000000;
         xtalTick <= 1'b0;
      end else begin
         phaseAcc <= nextPhase[23:0];
         xtalTick <= nextPhase[24];
      end
   end
   always @(posedge clock) begin
      if (sys_rst) begin
         steerState <= ST_IDLE;
         guardCnt   <= 24'h000000;
         pendCode   <= 4'h0;
         guard_drive <= 1'b0;
      end else begin
         case (steerState)
            ST_IDLE: begin
               guard_drive <= 1'b0;
               guardCnt    <= 24'h000000;
               if (steerNow && !cpMode) begin
                  steerState <= ST_PRESENT;
               end
            end
            ST_PRESENT: begin
               if (!steerNow || cpMode) begin
                  steerState <= ST_IDLE;
               end else if (xtalTick) begin
                  if (guardCnt >= gtpCount) begin
                     steerState  <= ST_HELD;
                     pendCode    <= codeSync;
                     guard_drive <= 1'b1;
                     guardCnt    <= 24'h000000;
                  end else begin
                     guardCnt <= guardCnt + 24'h000001;
                  end
               end
            end
            ST_HELD: begin
               guard_drive <= steerNow;
               guardCnt    <= 24'h000000;
               if (!steerNow) begin
                  steerState <= ST_ABSENT;
               end
            end
            ST_ABSENT: begin
               if (steerNow) begin
                  steerState  <= ST_HELD;
                  guard_drive <= 1'b1;
               end else if (xtalTick) begin
                  if (guardCnt >= gtaCount) begin
                     steerState <= ST_IDLE;
                  end else begin
                     guardCnt <= guardCnt + 24'h000001;
                  end
               end
            end
            default: steerState <= ST_IDLE;
         endcase
      end
   end
   always @(posedge clock) begin
      if (sys_rst) begin
         settling      <= 1'b0;
         settleCnt     <= 4'h0;
         delayed_steer <= 1'b0;
         rx_code_bits  <= 4'h0;
      end else begin
         if (steerState == ST_PRESENT && xtalTick && steerNow && !cpMode
             && guardCnt >= gtpCount) begin
            settling  <= 1'b1;
            settleCnt <= 4'h0;
         end else if (settling) begin
            if (settleCnt == SETTLE_LAST) begin
               settling      <= 1'b0;
               delayed_steer <= 1'b1;
               rx_code_bits  <= pendCode;
            end else begin
               settleCnt <= settleCnt + 4'h1;
            end
         end
         if (steerState == ST_IDLE) begin
            delayed_steer <= 1'b0;
         end
      end
   end
   always @* begin
      // code map, dividers per segment at crystal rate
      case (txCode)
         4'h1, 4'h2, 4'h3, 4'hd: lowDiv = 12'd160;
         4'h4, 4'h5, 4'h6, 4'he: lowDiv = 12'd145;
         4'h7, 4'h8, 4'h9, 4'hf: lowDiv = 12'd131;
         default:                lowDiv = 12'd119;
      endcase
      case (txCode)
         4'h1, 4'h4, 4'h7, 4'hb: highDiv = 12'd92;
         4'h2, 4'h5, 4'h8, 4'ha: highDiv = 12'd84;
         4'h3, 4'h6, 4'h9, 4'hc: highDiv = 12'd76;
         default:                highDiv = 12'd68;
      endcase
   end
   dtsb_tone_gen #(.DIV_W(12)) lowTone (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .tick     (xtalTick),
      .run      (genRun),
      .divCount (lowDiv),
      .sample   (lowSample)
   );
   dtsb_tone_gen #(.DIV_W(12)) highTone (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .tick     (xtalTick),
      .run      (genRun),
      .divCount (highDiv),
      .sample   (highSample)
   );
   always @(posedge clock) begin
      if (sys_rst) begin
         burstState <= B_IDLE;
         burstCnt   <= 32'h00000000;
      end else if (!burstOn || !ctrl[`DTSB_CTRL_TONE_OUTPUT_ENABLE]) begin
         burstState <= B_IDLE;
         burstCnt   <= 32'h00000000;
      end else begin
         case (burstState)
            B_IDLE: begin
               burstCnt <= 32'h00000000;
               if (setupWr && paddr == `DTSB_ADDR_TXDATA) begin
                  burstState <= B_TONE;
               end
            end
            B_TONE: begin
               if (burstCnt >= burstLimit - 32'h00000001) begin
                  burstState <= B_PAUSE;
                  burstCnt   <= 32'h00000000;
               end else begin
                  burstCnt <= burstCnt + 32'h00000001;
               end
            end
            B_PAUSE: begin
               if (burstCnt >= burstLimit - 32'h00000001) begin
                  burstState <= B_IDLE;
               end else begin
                  burstCnt <= burstCnt + 32'h00000001;
               end
            end
            default: burstState <= B_IDLE;
         endcase
      end
   end
   // Register file and APB slave, zero wait states
   always @(posedge clock) begin
      if (sys_rst) begin
         ctrl     <= `DTSB_CTRL_RESET;
         gtpCount <= `DTSB_GTP_RESET;
         gtaCount <= `DTSB_GTA_RESET;
         txCode   <= 4'h0;
         txReady  <= 1'b1;
         rxValid  <= 1'b0;
         irqPend  <= 1'b0;
         prdata   <= 32'h00000000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (setupWr && pready) begin
            case (paddr)
               `DTSB_ADDR_TXDATA: txCode   <= pwdata[3:0];
               `DTSB_ADDR_CTRL:   ctrl     <= pwdata[3:0];
               `DTSB_ADDR_GTP:    gtpCount <= pwdata[23:0];
               `DTSB_ADDR_GTA:    gtaCount <= pwdata[23:0];
               default:           pslverr  <= 1'b0;
            endcase
         end
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `DTSB_ADDR_RXDATA: prdata <= {28'h0000000, rx_code_bits};
               `DTSB_ADDR_TXDATA: prdata <= {28'h0000000, txCode};
               `DTSB_ADDR_CTRL:   prdata <= {28'h0000000, ctrl};
               `DTSB_ADDR_STATUS: prdata <= {28'h0000000, delayed_steer, rxValid,
                                             txReady, irqPend};
               `DTSB_ADDR_GTP:    prdata <= {8'h00, gtpCount};
               `DTSB_ADDR_GTA:    prdata <= {8'h00, gtaCount};
               default:           prdata <= 32'h00000000;
            endcase
         end else if (!psel) begin
            prdata <= 32'h00000000;
         end
         if (psel && !penable) begin
            pslverr <= (paddr > `DTSB_ADDR_GTA) || (paddr[1:0] != 2'b00);
         end
         if (accessRd && pready && paddr == `DTSB_ADDR_STATUS) begin
            rxValid <= 1'b0;
            irqPend <= 1'b0;
         end
         if (settling && settleCnt == SETTLE_LAST) begin
            rxValid <= 1'b1;
            irqPend <= 1'b1;
         end
         if (setupWr && pready && paddr == `DTSB_ADDR_TXDATA && burstOn) begin
            txReady <= 1'b0;
         end else if (burstState == B_PAUSE && burstCnt >= burstLimit - 32'h00000001) begin
            txReady <= 1'b1;
         end
      end
   end
   // shared pin, oe high pulls low
   always @(posedge clock) begin
      if (sys_rst) begin
         irq_or_tone_square_oe <= 1'b0;
         low_tone_sample       <= 8'h80;
         high_tone_sample      <= 8'h80;
         tone_active           <= 1'b0;
      end else begin
         if (!ctrl[`DTSB_CTRL_IRQEN]) begin
            irq_or_tone_square_oe <= 1'b0;
         end else if (cpMode) begin
            irq_or_tone_square_oe <= !(syncBand[1] && syncSquare[1]);
         end else begin
            irq_or_tone_square_oe <= irqPend;
         end
         low_tone_sample  <= lowSample;
         high_tone_sample <= highSample;
         tone_active      <= genRun;
      end
   end
endmodule // dtsb_core
`default_nettype wire

// File: dtsb_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dtsb_core_assertions #(
   parameter BURST_MS = 51
) (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        early_steer,
   input wire logic        guard_drive,
   input wire logic        delayed_steer,
   input wire logic [3:0]  rx_code_bits,
   input wire logic [7:0]  low_tone_sample,
   input wire logic [7:0]  high_tone_sample,
   input wire logic        tone_active
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   property p_readyAfterSetup;
      psel && !penable |=> pready && penable;
   endproperty
   a_readyAfterSetup: assert property (p_readyAfterSetup)
      else $error("ready missing after setup");

   property p_readyInAccess;
      pready |-> psel && penable && $past(psel);
   endproperty
   a_readyInAccess: assert property (p_readyInAccess)
      else $error("ready outside access");

   property p_errOnUnmapped;
      pready && (paddr > 12'h014 || paddr[1:0] != 2'b00)
         |-> pslverr && (pwrite || prdata == 32'h0);
   endproperty
   a_errOnUnmapped: assert property (p_errOnUnmapped)
      else $error("unmapped access not refused");

   property p_okOnMapped;
      pready && paddr <= 12'h014 && paddr[1:0] == 2'b00 |-> !pslverr;
   endproperty
   a_okOnMapped: assert property (p_okOnMapped)
      else $error("mapped access refused");

   property p_latchOnSteer;
      $changed(rx_code_bits) |-> ##[0:8] $rose(delayed_steer);
   endproperty
   a_latchOnSteer: assert property (p_latchOnSteer)
      else $error("receive code changed without steer");

   // Flag waits for the latch to settle, so never on the guard edge itself
   property p_settleDelay;
      $rose(guard_drive) && !delayed_steer |-> !delayed_steer ##[1:6] $rose(delayed_steer);
   endproperty
   a_settleDelay: assert property (p_settleDelay)
      else $error("steer flag timing");

   property p_guardFollowsSteer;
      $fell(early_steer) |-> ##[1:4] !guard_drive;
   endproperty
   a_guardFollowsSteer: assert property (p_guardFollowsSteer)
      else $error("guard held after steer loss");

   property p_flagNeedsGuard;
      $rose(delayed_steer) |-> guard_drive;
   endproperty
   a_flagNeedsGuard: assert property (p_flagNeedsGuard)
      else $error("flag without registration");

   property p_idleSamples;
      !tone_active && $past(!tone_active)
         |-> low_tone_sample == 8'h80 && high_tone_sample == 8'h80;
   endproperty
   a_idleSamples: assert property (p_idleSamples)
      else $error("tone output while gated");

   c_latch: cover property ($rose(delayed_steer));
   c_refused: cover property (pready && pslverr);
   c_burst: cover property ($fell(tone_active));
endmodule // dtsb_core_assertions

bind dtsb_core dtsb_core_assertions #(.BURST_MS(BURST_MS)) u_chk (
   .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .early_steer(early_steer), .guard_drive(guard_drive),
   .delayed_steer(delayed_steer), .rx_code_bits(rx_code_bits),
   .low_tone_sample(low_tone_sample), .high_tone_sample(high_tone_sample),
   .tone_active(tone_active));
`default_nettype wire

// File: dtsb_detector_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtsb_detector_model (
   input  wire logic       clock,
   input  wire logic       toneReq,
   input  wire logic [3:0] toneCode,
   input  wire logic       cpTone,
   input  wire logic       cpBand,
   output var  logic       early_steer,
   output var  logic [3:0] detected_code,
   output var  logic       cp_in_band,
   output var  logic       cp_limited
);
   logic [2:0] div = 3'h0;

   initial begin
      early_steer = 1'b0;
      detected_code = 4'h0;
      cp_in_band = 1'b0;
      cp_limited = 1'b0;
   end

   // Code is only promised while steering; flipping it otherwise exposes stale use
   always @(posedge clock) begin
      div <= div + 3'h1;
      early_steer <= toneReq;
      detected_code <= toneReq ? toneCode : ~detected_code;
      cp_in_band <= cpTone && cpBand;
      cp_limited <= cpTone && div[2];
   end
endmodule // dtsb_detector_model
`default_nettype wire

// File: dtsb_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtsb_consts.vh"
module dtsb_core_bench;
   localparam int BMS  = 1;
   localparam int BCYC = BMS * 100000;
   // Expected sine steps per burst: tone frequency times 32 segments
   localparam int LSTEP = 941 * 32 * BMS / 1000;
   localparam int HSTEP = 1477 * 32 * BMS / 1000;
   logic        clock;
   logic        sys_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic        toneReq;
   logic [3:0]  toneCode;
   logic        cpTone;
   logic        cpBand;
   logic [31:0] rd;
   logic        er;
   int          failCount = 0;
   int          cmpCount = 0;
   wire logic [31:0] prdata;
   wire logic        pready;
   wire logic        pslverr;
   wire logic        early_steer;
   wire logic [3:0]  detected_code;
   wire logic        cp_in_band;
   wire logic        cp_limited;
   wire logic        guard_drive;
   wire logic        irqOe;
   wire logic        delayed_steer;
   wire logic [3:0]  rx_code_bits;
   wire logic [7:0]  lowS;
   wire logic [7:0]  highS;
   wire logic        tone_active;

   dtsb_core #(.BURST_MS(BMS)) u_dut (
      .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .early_steer(early_steer),
      .detected_code(detected_code), .cp_in_band(cp_in_band),
      .cp_limited(cp_limited), .guard_drive(guard_drive),
      .irq_or_tone_square_oe(irqOe), .delayed_steer(delayed_steer),
      .rx_code_bits(rx_code_bits), .low_tone_sample(lowS),
      .high_tone_sample(highS), .tone_active(tone_active));

   dtsb_detector_model u_det (
      .clock(clock), .toneReq(toneReq), .toneCode(toneCode), .cpTone(cpTone),
      .cpBand(cpBand), .early_steer(early_steer), .detected_code(detected_code),
      .cp_in_band(cp_in_band), .cp_limited(cp_limited));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic endSim();
      $display("comparisons %0d mismatches %0d", cmpCount, failCount);
      if (failCount == 0 && cmpCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp) begin
         failCount++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Request held until pready is sampled high; the idle edge after avoids double drive
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      chk("apb answer", 32'h1, {31'h0, pready});
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic waitDs(input logic lvl);
      int n;
      n = 0;
      while (delayed_steer !== lvl && n < 400) begin
         n++;
         @(posedge clock);
      end
      chk("steer flag", {31'h0, lvl}, {31'h0, delayed_steer});
   endtask

   task automatic regsAfterReset();
      apb(1'b0, `DTSB_ADDR_CTRL, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      apb(1'b0, `DTSB_ADDR_GTP, 32'h0);
      chk("present guard reset", 32'h00f000, rd);
      apb(1'b0, `DTSB_ADDR_STATUS, 32'h0);
      chk("tx ready reset", 32'h2, rd & 32'h2);
      apb(1'b1, 12'h018, 32'hf);
      chk("unmapped", 32'h1, {31'h0, er});
      apb(1'b0, 12'h002, 32'h0);
      chk("unaligned", 32'h1, {31'h0, er});
      apb(1'b1, `DTSB_ADDR_GTP, 32'h2);
      apb(1'b1, `DTSB_ADDR_GTA, 32'h2);
      apb(1'b0, `DTSB_ADDR_GTA, 32'h0);
      chk("absent guard", 32'h2, rd);
      apb(1'b1, `DTSB_ADDR_CTRL, 32'h4);
   endtask

   task automatic shortBurst();
      toneCode <= 4'h5;
      toneReq <= 1'b1;
      repeat (30) @(posedge clock);
      toneReq <= 1'b0;
      repeat (150) @(posedge clock);
      apb(1'b0, `DTSB_ADDR_STATUS, 32'h0);
      chk("short valid", 32'h0, rd & 32'h5);
      chk("short code", 32'h0, {28'h0, rx_code_bits});
   endtask

   task automatic digitRun(input logic [3:0] c);
      toneCode <= c;
      toneReq <= 1'b1;
      waitDs(1'b1);
      chk("guard on", 32'h1, {31'h0, guard_drive});
      chk("latched", {28'h0, c}, {28'h0, rx_code_bits});
      apb(1'b0, `DTSB_ADDR_RXDATA, 32'h0);
      chk("rx read", {28'h0, c}, rd);
      chk("irq pin", 32'h1, {31'h0, irqOe});
      apb(1'b0, `DTSB_ADDR_STATUS, 32'h0);
      chk("rx valid", 32'hd, rd & 32'hd);
      apb(1'b0, `DTSB_ADDR_STATUS, 32'h0);
      chk("status cleared", 32'h8, rd & 32'hd);
      toneReq <= 1'b0;
      waitDs(1'b0);
      chk("guard off", 32'h0, {31'h0, guard_drive});
      chk("irq off", 32'h0, {31'h0, irqOe});
      chk("retained", {28'h0, c}, {28'h0, rx_code_bits});
   endtask

   task automatic dropout();
      int n;
      n = 0;
      toneCode <= 4'h3;
      toneReq <= 1'b1;
      waitDs(1'b1);
      toneReq <= 1'b0;
      for (int i = 0; i < 120; i++) begin
         if (i == 15) toneReq <= 1'b1;
         @(posedge clock);
         if (delayed_steer !== 1'b1) n++;
      end
      chk("dropout ignored", 32'h0, n);
      toneReq <= 1'b0;
      waitDs(1'b0);
   endtask

   task automatic cpMode();
      int t;
      logic p;
      t = 0;
      apb(1'b1, `DTSB_ADDR_CTRL, 32'h6);
      cpTone <= 1'b1;
      cpBand <= 1'b1;
      toneCode <= 4'h9;
      toneReq <= 1'b1;
      repeat (10) @(posedge clock);
      p = irqOe;
      repeat (200) begin
         @(posedge clock);
         if (irqOe !== p) t++;
         p = irqOe;
      end
      chk("in band square", 32'h1, {31'h0, t > 10});
      chk("no digit in cp", 32'h0, {31'h0, delayed_steer});
      chk("rx kept", 32'h3, {28'h0, rx_code_bits});
      cpBand <= 1'b0;
      toneReq <= 1'b0;
      repeat (10) @(posedge clock);
      t = 0;
      p = irqOe;
      repeat (100) begin
         @(posedge clock);
         if (irqOe !== p) t++;
      end
      chk("out of band still", 32'h0, t);
      cpTone <= 1'b0;
      apb(1'b1, `DTSB_ADDR_CTRL, 32'h0);
   endtask

   // Code c is 941 Hz row and 1477 Hz column; 32 steps each period
   task automatic burst();
      int n;
      int nl;
      int nh;
      logic [7:0] pl;
      logic [7:0] ph;
      n = 0;
      nl = 0;
      nh = 0;
      apb(1'b1, `DTSB_ADDR_TXDATA, 32'h5);
      repeat (50) @(posedge clock);
      chk("gated", 32'h0, {31'h0, tone_active});
      apb(1'b1, `DTSB_ADDR_CTRL, 32'h1);
      repeat (4) @(posedge clock);
      chk("host keyed tone", 32'h1, {31'h0, tone_active});
      apb(1'b1, `DTSB_ADDR_CTRL, 32'h0);
      repeat (4) @(posedge clock);
      chk("host unkeyed", 32'h0, {31'h0, tone_active});
      apb(1'b1, `DTSB_ADDR_CTRL, 32'h9);
      apb(1'b1, `DTSB_ADDR_TXDATA, 32'hc);
      while (tone_active !== 1'b1 && n < 100) begin
         n++;
         @(posedge clock);
      end
      n = 0;
      pl = lowS;
      ph = highS;
      while (tone_active === 1'b1 && n < 2 * BCYC) begin
         @(posedge clock);
         n++;
         if (lowS !== pl) nl++;
         if (highS !== ph) nh++;
         pl = lowS;
         ph = highS;
      end
      chk("low steps", 32'h1, {31'h0, nl >= LSTEP - 2 && nl <= LSTEP + 2});
      chk("high steps", 32'h1, {31'h0, nh >= HSTEP - 2 && nh <= HSTEP + 2});
      chk("burst length", 32'h1, {31'h0, n > BCYC - BCYC / 51 && n < BCYC + BCYC / 51});
      apb(1'b0, `DTSB_ADDR_STATUS, 32'h0);
      chk("ready after pause only", 32'h0, rd & 32'h2);
   endtask

   initial begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      toneReq = 1'b0;
      toneCode = 4'h0;
      cpTone = 1'b0;
      cpBand = 1'b0;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      regsAfterReset();
      shortBurst();
      for (int c = 0; c < 16; c++) begin
         digitRun(c[3:0]);
      end
      dropout();
      cpMode();
      burst();
      endSim();
   end

   initial begin
      repeat (130000) @(posedge clock);
      failCount++;
      endSim();
   end
endmodule // dtsb_core_bench
`default_nettype wire
